// >>> rtl/mcc_pkg.sv
// Package of constants, types and register map of the master clock controller
package mcc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_SRC_SEL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PRESCALE = 8'h08;
    localparam logic [7:0] ADDR_GATE_ONE = 8'h0C;
    localparam logic [7:0] ADDR_GATE_TWO = 8'h10;
    localparam logic [7:0] ADDR_CORE_GATE = 8'h14;
    localparam logic [7:0] ADDR_MONITOR = 8'h18;
    localparam logic [7:0] ADDR_CLK_OUT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

    // ------------------------------------------------------------------
    // Master clock sources
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_INT_FAST = 2'b00,
        SRC_EXT_XTAL = 2'b01,
        SRC_EXT_USER = 2'b10,
        SRC_INT_SLOW = 2'b11
    } mcc_src_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT_READY = 2'b01,
        SW_WAIT_LOW = 2'b10
    } mcc_sw_state_t;

    // Oscillator waveforms and ready flags, indexed by source code
    typedef struct packed {
        logic [3:0] wave;
        logic [3:0] ready;
    } mcc_osc_t;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int PRE_W = 3;
    localparam int PRE_CNT_W = 7;
    localparam logic [2:0] PRESCALE_RESET = 3'h3;
    localparam logic [7:0] GATE_ONE_RESET = 8'hFF;
    localparam logic [7:0] GATE_TWO_MASK = 8'h8C;
    localparam logic [7:0] GATE_TWO_RESET = 8'h8C;
    localparam logic [1:0] CORE_GATE_RESET = 2'h3;
    localparam int NUM_GATES = 18;
    localparam int IRQ_SWITCH_DONE = 0;
    localparam int IRQ_CLOCK_FAIL = 1;
    localparam int STAT_BUSY = 2;
    localparam int MON_ENABLE = 0;
    localparam int OUT_ENABLE = 0;

    // Clock output selection codes, field bits [3:1]
    localparam logic [2:0] OUT_SEL_MASTER = 3'h0;
    localparam logic [2:0] OUT_SEL_CPU = 3'h1;
    localparam logic [2:0] OUT_SEL_INT_FAST = 3'h2;
    localparam logic [2:0] OUT_SEL_INT_SLOW = 3'h3;
    localparam logic [2:0] OUT_SEL_EXT = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int FAIL_TIME_NS = 1000;
    localparam int FAIL_CYCLES_INT = FAIL_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] FAIL_CYCLES = FAIL_CYCLES_INT[7:0];

endpackage

// >>> rtl/mcc_sync.sv
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module mcc_sync #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output var logic [W-1:0] q
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> rtl/mcc_prescaler.sv
// Power-of-two prescaler of the master clock
`timescale 1ns/1ps
`default_nettype none
module mcc_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mclk,
    input wire logic [mcc_pkg::PRE_W-1:0] ratio,
    output var logic div_clk
);
    logic mclk_d;
    logic [mcc_pkg::PRE_CNT_W-1:0] cnt;
    logic [mcc_pkg::PRE_W-1:0] ratio_act;
    logic [mcc_pkg::PRE_CNT_W-1:0] cnt_inc;
    logic [mcc_pkg::PRE_CNT_W-1:0] wrap_mask;
    logic [mcc_pkg::PRE_CNT_W-1:0] cnt_half;
    wire rise = mclk & ~mclk_d;
    wire wrap = ((cnt_inc & wrap_mask) == '0);
    logic next_div;

    assign cnt_inc = cnt + 1'b1;
    assign wrap_mask = (mcc_pkg::PRE_CNT_W)'((8'h01 << ratio_act) - 8'h01);
    assign cnt_half = (mcc_pkg::PRE_CNT_W)'(8'h01 << (ratio - 3'h1));

    // Ratio only changes at the end of a whole divided period, so no short pulse
    always_comb begin
        if (ratio_act == '0) begin
            next_div = mclk;
        end else begin
            next_div = cnt[ratio_act - 1'b1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_d <= 1'b0;
            cnt <= '0;
            ratio_act <= mcc_pkg::PRESCALE_RESET;
            div_clk <= 1'b0;
        end else begin
            mclk_d <= mclk;
            div_clk <= next_div;
            if (rise && wrap) begin
                // Leaving undivided mode on a high pulse: start in the high half, keep it whole
                cnt <= (ratio_act == '0) ? cnt_half : '0;
                ratio_act <= ratio;
            end else if (rise) begin
                cnt <= cnt_inc;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/mcc_top.sv
// Master clock controller: source switch, prescaler, gating, monitor, clock output
// Overview of operation
// R1: After reset run from internal fast RC divided by eight, two MHz.
// R2: Keep the old source until the requested new source reports ready.
// R3: Change sources only at low phases, never a truncated pulse; a forced fallback does not wait for the old source's low phase.
// R4: Four sources: crystal, user external clock, fast RC, slow RC.
// R5: Software changes the source through a register while running.
// R6: Master clock passes a software-programmable prescaler to CPU and peripherals.
// R7: Monitor sees external clock loss, falls back to fast RC over eight, interrupts.
// R8: Clocks to core, each peripheral and memory can be stopped individually.
// R9: Gate bits map to timers, serial ports, SPI, I2C, CAN, ADC, auto-wakeup.
// R10: A configurable clock output drives a selected internal clock to a pin.
// R11: Reserved gate bits read zero and never enable any clock.
`timescale 1ns/1ps
`default_nettype none
module mcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mcc_pkg::mcc_osc_t osc,
    output logic master_clk,
    output logic cpu_clk,
    output logic core_clk,
    output logic mem_clk,
    output logic [15:0] periph_clk,
    output var logic clock_out_pin,
    output var logic clock_out_oe,
    output logic irq
);
    // ------------------------------------------------------------------
    // Oscillator inputs, resynchronised
    // ------------------------------------------------------------------
    logic [3:0] wave_s;
    logic [3:0] ready_s;

    mcc_sync #(.W(8)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({osc.ready, osc.wave}),
        .q({ready_s, wave_s})
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    mcc_pkg::mcc_src_t src_sel;
    mcc_pkg::mcc_src_t src_cur;
    mcc_pkg::mcc_src_t src_target;
    mcc_pkg::mcc_sw_state_t sw_state;
    logic [mcc_pkg::PRE_W-1:0] prescale;
    logic [7:0] gate_one;
    logic [7:0] gate_two;
    logic [1:0] core_gate;
    logic mon_ctrl;
    logic [3:0] out_ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic forced;
    logic mclk;
    logic fail_event;
    logic switch_done;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire setup = psel & ~penable;
    wire wr = psel & penable & pwrite;
    wire hit_sel = (paddr == mcc_pkg::ADDR_SRC_SEL);
    wire hit_stat = (paddr == mcc_pkg::ADDR_STATUS);
    wire hit_pre = (paddr == mcc_pkg::ADDR_PRESCALE);
    wire hit_g1 = (paddr == mcc_pkg::ADDR_GATE_ONE);
    wire hit_g2 = (paddr == mcc_pkg::ADDR_GATE_TWO);
    wire hit_core = (paddr == mcc_pkg::ADDR_CORE_GATE);
    wire hit_mon = (paddr == mcc_pkg::ADDR_MONITOR);
    wire hit_out = (paddr == mcc_pkg::ADDR_CLK_OUT);
    wire hit_ist = (paddr == mcc_pkg::ADDR_IRQ_STATUS);
    wire hit_imk = (paddr == mcc_pkg::ADDR_IRQ_MASK);
    wire hit_any = hit_sel | hit_stat | hit_pre | hit_g1 | hit_g2 | hit_core | hit_mon
                   | hit_out | hit_ist | hit_imk;
    wire [7:0] status_val = {ready_s, 1'b0, (sw_state != mcc_pkg::SW_IDLE), src_cur};
    logic [31:0] rd_mux;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit_sel: rd_mux = {30'h0000_0000, src_sel};
            hit_stat: rd_mux = {24'h00_0000, status_val};
            hit_pre: rd_mux = {29'h0000_0000, prescale};
            hit_g1: rd_mux = {24'h00_0000, gate_one};
            hit_g2: rd_mux = {24'h00_0000, gate_two}; // R11
            hit_core: rd_mux = {30'h0000_0000, core_gate};
            hit_mon: rd_mux = {31'h0000_0000, mon_ctrl};
            hit_out: rd_mux = {28'h000_0000, out_ctrl};
            hit_ist: rd_mux = {30'h0000_0000, irq_status};
            hit_imk: rd_mux = {30'h0000_0000, irq_mask};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup phase so it stands through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Software registers; a clock failure overrides selection and ratio
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel <= mcc_pkg::SRC_INT_FAST; // R1
            prescale <= mcc_pkg::PRESCALE_RESET; // R1
            gate_one <= mcc_pkg::GATE_ONE_RESET;
            gate_two <= mcc_pkg::GATE_TWO_RESET;
            core_gate <= mcc_pkg::CORE_GATE_RESET;
            mon_ctrl <= 1'b0;
            out_ctrl <= 4'h0;
            irq_mask <= 2'h0;
        end else if (fail_event) begin
            src_sel <= mcc_pkg::SRC_INT_FAST; // R7
            prescale <= mcc_pkg::PRESCALE_RESET; // R7
        end else if (wr) begin
            if (hit_sel) src_sel <= mcc_pkg::mcc_src_t'(pwdata[1:0]); // R5
            if (hit_pre) prescale <= pwdata[mcc_pkg::PRE_W-1:0]; // R6
            if (hit_g1) gate_one <= pwdata[7:0]; // R9
            if (hit_g2) gate_two <= pwdata[7:0] & mcc_pkg::GATE_TWO_MASK; // R9 R11
            if (hit_core) core_gate <= pwdata[1:0]; // R8
            if (hit_mon) mon_ctrl <= pwdata[mcc_pkg::MON_ENABLE];
            if (hit_out) out_ctrl <= pwdata[3:0];
            if (hit_imk) irq_mask <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: sticky, write one to clear, a new event wins
    // ------------------------------------------------------------------
    wire [1:0] irq_set = {fail_event, switch_done};
    wire [1:0] irq_clr = (wr && hit_ist) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set; // R7
        end
    end

    assign irq = |(irq_status & irq_mask); // R7

    // ------------------------------------------------------------------
    // Source switch sequencer
    // ------------------------------------------------------------------
    // A dead source may hold its wave high; on a forced change we cannot
    // wait for its low phase, and the cut comes at a falling edge anyway.
    // The live wave must be low too, or a pulse just entering mclk would be cut
    wire old_low = (~mclk & ~wave_s[src_cur]) | forced;
    wire new_low = ~wave_s[src_target];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_state <= mcc_pkg::SW_IDLE;
            src_cur <= mcc_pkg::SRC_INT_FAST; // R1
            src_target <= mcc_pkg::SRC_INT_FAST;
            forced <= 1'b0;
            switch_done <= 1'b0;
        end else begin
            switch_done <= 1'b0;
            if (fail_event) begin
                src_target <= mcc_pkg::SRC_INT_FAST; // R7
                forced <= 1'b1;
                sw_state <= mcc_pkg::SW_WAIT_READY;
            end else begin
                unique case (sw_state)
                    mcc_pkg::SW_IDLE: begin
                        if (src_sel != src_cur) begin
                            src_target <= src_sel; // R4 R5
                            forced <= 1'b0;
                            sw_state <= mcc_pkg::SW_WAIT_READY;
                        end
                    end
                    mcc_pkg::SW_WAIT_READY: begin
                        if (ready_s[src_target]) begin
                            sw_state <= mcc_pkg::SW_WAIT_LOW; // R2
                        end
                    end
                    mcc_pkg::SW_WAIT_LOW: begin
                        if (old_low && new_low) begin
                            src_cur <= src_target; // R3
                            switch_done <= 1'b1;
                            sw_state <= mcc_pkg::SW_IDLE;
                        end
                    end
                    default: begin
                        sw_state <= mcc_pkg::SW_IDLE;
                    end
                endcase
            end
        end
    end

    // Master clock follows the active source only; src_cur moves at a low phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk <= 1'b0;
        end else begin
            mclk <= wave_s[src_cur]; // R2 R3
        end
    end

    assign master_clk = mclk;

    // ------------------------------------------------------------------
    // Clock failure monitor on the active external source, crystal or user clock
    // ------------------------------------------------------------------
    logic ext_d;
    logic [7:0] idle_cnt;
    wire cur_ext = (src_cur == mcc_pkg::SRC_EXT_XTAL) | (src_cur == mcc_pkg::SRC_EXT_USER);
    wire ext_wave = wave_s[src_cur];
    wire ext_edge = ext_wave ^ ext_d;
    wire mon_armed = mon_ctrl & cur_ext & (sw_state == mcc_pkg::SW_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_d <= 1'b0;
            idle_cnt <= 8'h00;
            fail_event <= 1'b0;
        end else begin
            ext_d <= ext_wave;
            fail_event <= 1'b0;
            if (!mon_armed || ext_edge) begin
                idle_cnt <= 8'h00;
            end else if (idle_cnt == mcc_pkg::FAIL_CYCLES) begin
                fail_event <= 1'b1; // R7
                idle_cnt <= 8'h00;
            end else begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Prescaler and per-destination gating
    // ------------------------------------------------------------------
    mcc_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .mclk(mclk),
        .ratio(prescale),
        .div_clk(cpu_clk)
    );

    wire [mcc_pkg::NUM_GATES-1:0] gate_vec = {core_gate, gate_two, gate_one};
    logic [mcc_pkg::NUM_GATES-1:0] gate_en;
    logic [mcc_pkg::NUM_GATES-1:0] gated;

    // Enables move only while the divided clock is low, so pulses stay whole
    genvar g;
    generate
        for (g = 0; g < mcc_pkg::NUM_GATES; g++) begin : g_gate
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_en[g] <= 1'b0;
                    gated[g] <= 1'b0;
                end else begin
                    if (!cpu_clk) gate_en[g] <= gate_vec[g]; // R8 R11
                    gated[g] <= cpu_clk & gate_en[g]; // R8
                end
            end
        end
    endgenerate

    assign periph_clk = gated[15:0]; // R9
    assign core_clk = gated[16];
    assign mem_clk = gated[17];

    // ------------------------------------------------------------------
    // Clock output pin
    // ------------------------------------------------------------------
    wire [2:0] out_sel = out_ctrl[3:1];
    logic out_src;

    always_comb begin
        unique case (out_sel)
            mcc_pkg::OUT_SEL_MASTER: out_src = mclk;
            mcc_pkg::OUT_SEL_CPU: out_src = cpu_clk;
            mcc_pkg::OUT_SEL_INT_FAST: out_src = wave_s[mcc_pkg::SRC_INT_FAST];
            mcc_pkg::OUT_SEL_INT_SLOW: out_src = wave_s[mcc_pkg::SRC_INT_SLOW];
            mcc_pkg::OUT_SEL_EXT: out_src = wave_s[mcc_pkg::SRC_EXT_XTAL];
            default: out_src = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_pin <= 1'b0;
            clock_out_oe <= 1'b0;
        end else begin
            clock_out_pin <= out_src & out_ctrl[mcc_pkg::OUT_ENABLE]; // R10
            clock_out_oe <= out_ctrl[mcc_pkg::OUT_ENABLE]; // R10
        end
    end
endmodule
`default_nettype wire

// >>> tb/mcc_osc_model.sv
// Behavioural oscillators that feed the master clock controller
`timescale 1ns/1ps
`default_nettype none
module mcc_osc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] rdy,
    input wire logic stop_xtal,
    output wire mcc_pkg::mcc_osc_t osc
);
    // Half periods in pclk cycles, kept well below pclk/2 so the sampled waves stay true
    localparam int HALF [4] = '{2, 3, 4, 8};
    logic [3:0] wave;
    int cnt [4];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave <= 4'h0;
            for (int i = 0; i < 4; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                // A stopped crystal freezes at its last level, as a dead oscillator would
                if (!(i == 1 && stop_xtal)) begin
                    cnt[i] <= (cnt[i] == HALF[i] - 1) ? 0 : cnt[i] + 1;
                    if (cnt[i] == HALF[i] - 1) wave[i] <= ~wave[i];
                end
            end
        end
    end
    assign osc = {wave, rdy};
endmodule
`default_nettype wire

// >>> tb/mcc_props.sv
// Port-level checker of the master clock controller
`timescale 1ns/1ps
`default_nettype none
module mcc_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_clk,
    input wire logic cpu_clk,
    input wire logic core_clk,
    input wire logic mem_clk,
    input wire logic [15:0] periph_clk,
    input wire logic clock_out_pin,
    input wire logic clock_out_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic unmapped;
    assign acc = psel && penable;
    assign unmapped = (paddr > mcc_pkg::ADDR_IRQ_MASK) || (paddr[1:0] != 2'h0);
    a_pready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc |-> pslverr == unmapped) else $error("pslverr wrong");
    a_unmapped_zero: assert property (acc && !pwrite && unmapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_mask_clear: assert property (acc && pwrite && paddr == mcc_pkg::ADDR_IRQ_MASK
        && pwdata[1:0] == 2'h0 |=> !irq) else $error("irq high with mask clear");
    a_clkout_gate: assert property (!clock_out_oe |-> !clock_out_pin)
        else $error("clock output active while disabled");
    a_master_pulse: assert property ($rose(master_clk) |=> master_clk)
        else $error("truncated master pulse");
    a_cpu_pulse: assert property ($rose(cpu_clk) |=> cpu_clk)
        else $error("truncated cpu pulse");
    a_gated_delay: assert property (core_clk || mem_clk || |periph_clk |-> $past(cpu_clk))
        else $error("gated clock without cpu clock");
    a_reserved_off: assert property (periph_clk[14:12] == 3'h0 && periph_clk[9:8] == 2'h0)
        else $error("reserved gate clock running");
endmodule
`default_nettype wire

// >>> tb/test_mcc_top.sv
// Self-checking bench of the master clock controller
`timescale 1ns/1ps
`default_nettype none
module test_mcc_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, master_clk, cpu_clk, core_clk, mem_clk, irq, err;
    logic [15:0] periph_clk;
    logic clock_out_pin, clock_out_oe;
    logic [3:0] rdy = 4'hD;
    logic stop_xtal = 1'b0;
    mcc_pkg::mcc_osc_t osc;
    int miscompares = 0;
    int checked = 0;
    always #10 pclk = ~pclk;
    mcc_osc_model mcc_osc_model_inst (.pclk(pclk), .presetn(presetn), .rdy(rdy),
        .stop_xtal(stop_xtal), .osc(osc));
    mcc_top mcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc(osc), .master_clk(master_clk), .cpu_clk(cpu_clk),
        .core_clk(core_clk), .mem_clk(mem_clk), .periph_clk(periph_clk),
        .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .irq(irq));
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Interrupt level is looked at once the register write has settled
    task automatic irq_chk(input logic e);
        @(negedge pclk);
        cmp({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        cmp(rd, e);
    endtask
    // Period between the second and third rising edge, so a ratio change has settled
    task automatic per_chk(input int sel, input logic [31:0] exp);
        int i, e, first;
        logic p, c;
        e = 0;
        first = 0;
        p = 1'b1;
        for (i = 0; i < 600 && e < 3; i++) begin
            @(negedge pclk);
            c = (sel == 0) ? cpu_clk : (sel == 1) ? master_clk : clock_out_pin;
            if (c === 1'b1 && p === 1'b0) begin
                e++;
                if (e == 2) first = i;
                if (e == 3) cmp(32'(i - first), exp);
            end
            p = c;
        end
        if (e < 3) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic gate_chk(input logic [17:0] exp);
        logic [17:0] seen;
        seen = 18'h0_0000;
        repeat (8) @(negedge pclk);
        repeat (40) begin
            @(negedge pclk);
            seen |= {mem_clk, core_clk, periph_clk};
        end
        cmp({14'h0000, seen}, exp);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 500; n++) begin
            @(negedge pclk);
            if (irq === 1'b1) break;
        end
        if (n == 500) begin
            miscompares++;
            conclude();
        end
    endtask
    logic [1:0] srcs [3] = '{2'h2, 2'h3, 2'h1};
    int pers [3] = '{8, 16, 6};
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(mcc_pkg::ADDR_SRC_SEL, 32'h0000_0000);
        rdc(mcc_pkg::ADDR_PRESCALE, 32'h0000_0003);
        rdc(mcc_pkg::ADDR_GATE_ONE, 32'h0000_00FF);
        rdc(mcc_pkg::ADDR_GATE_TWO, 32'h0000_008C);
        rdc(mcc_pkg::ADDR_CORE_GATE, 32'h0000_0003);
        rdc(mcc_pkg::ADDR_MONITOR, 32'h0000_0000);
        rdc(mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        rdc(mcc_pkg::ADDR_STATUS, 32'h0000_00D0);
        per_chk(0, 32'h0000_0020);
        apb(1'b1, mcc_pkg::ADDR_PRESCALE, 32'h0000_0000);
        per_chk(0, 32'h0000_0004);
        apb(1'b1, mcc_pkg::ADDR_PRESCALE, 32'h0000_0001);
        per_chk(0, 32'h0000_0008);
        rdc(8'h30, 32'h0000_0000);
        cmp({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b1, mcc_pkg::ADDR_GATE_TWO, 32'h0000_00FF);
        apb(1'b1, mcc_pkg::ADDR_CORE_GATE, 32'h0000_0001);
        rdc(mcc_pkg::ADDR_GATE_TWO, 32'h0000_008C);
        for (int b = 0; b < 8; b++) begin
            apb(1'b1, mcc_pkg::ADDR_GATE_ONE, 32'h0000_0001 << b);
            gate_chk({2'h1, 8'h8C, 8'(8'h01 << b)});
        end
        apb(1'b1, mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, mcc_pkg::ADDR_SRC_SEL, {30'h0000_0000, srcs[k]});
            if (srcs[k] == 2'h1) begin
                repeat (60) @(posedge pclk);
                rdc(mcc_pkg::ADDR_STATUS, 32'h0000_00D7);
                cmp({31'h0000_0000, irq}, 32'h0000_0000);
                rdy[1] <= 1'b1;
            end
            wait_irq();
            rdc(mcc_pkg::ADDR_STATUS, {24'h00_0000, rdy, 2'h0, srcs[k]});
            per_chk(1, 32'(pers[k]));
            rdc(mcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
            apb(1'b1, mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
            irq_chk(1'b0);
            apb(1'b1, mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
            irq_chk(1'b1);
            apb(1'b1, mcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
            irq_chk(1'b0);
        end
        apb(1'b1, mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        apb(1'b1, mcc_pkg::ADDR_MONITOR, 32'h0000_0001);
        stop_xtal <= 1'b1;
        wait_irq();
        repeat (20) @(posedge pclk);
        rdc(mcc_pkg::ADDR_SRC_SEL, 32'h0000_0000);
        rdc(mcc_pkg::ADDR_PRESCALE, 32'h0000_0003);
        rdc(mcc_pkg::ADDR_STATUS, 32'h0000_00F0);
        apb(1'b0, mcc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
        cmp(rd & 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, mcc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        irq_chk(1'b0);
        per_chk(0, 32'h0000_0020);
        apb(1'b1, mcc_pkg::ADDR_CLK_OUT, 32'h0000_0005);
        per_chk(2, 32'h0000_0004);
        cmp({31'h0000_0000, clock_out_oe}, 32'h0000_0001);
        apb(1'b1, mcc_pkg::ADDR_CLK_OUT, 32'h0000_0003);
        per_chk(2, 32'h0000_0020);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(mcc_pkg::ADDR_PRESCALE, 32'h0000_0003);
        rdc(mcc_pkg::ADDR_CLK_OUT, 32'h0000_0000);
        conclude();
    end
endmodule
bind mcc_top mcc_props mcc_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clk(master_clk), .cpu_clk(cpu_clk),
    .core_clk(core_clk), .mem_clk(mem_clk), .periph_clk(periph_clk),
    .clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe), .irq(irq));
`default_nettype wire
